// ===== hdl/irq_edge_source_master_ctl.sv
// Edge polarity, shared source selection and master enable of the interrupt unit
`timescale 1ns/100ps
// Overview of operation
// - Each port A input raises its request on a falling edge when its polarity bit is 0, rising when 1.
// - Shared line 7 comes from pin 7 when its select bit is 0 and from the low-voltage detector when 1.
// - Shared line 6 comes from pin 6 when its select bit is 0 and from the comparator when 1.
// - Edges on shared lines are seen after the source mux, so switching source may raise a request.
// - The master enable is set by an enable or return instruction or by writing 1 to it.
// - The master enable is cleared by a disable instruction, an acknowledge, reset or writing 0.
// - While the master enable is 0 no request reaches the core; while 1 enabled requests pass.
// - The seven low bits of the control register are reserved, read as zero and ignore writes.
// - Each request's enable high/low pair means 00 off, 01 low, 10 medium, 11 high priority.
module irq_edge_source_master_ctl #(
    parameter int REQ_N = 24
) (
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    input  wire logic                            hsel,
    input  wire logic [irq_edge_pkg::ADDR_W-1:0] haddr,
    input  wire logic [1:0]                      htrans,
    input  wire logic                            hwrite,
    input  wire logic [2:0]                      hsize,
    input  wire logic [31:0]                     hwdata,
    input  wire logic                            hready,
    output logic                                 hreadyout,
    output logic                                 hresp,
    output logic      [31:0]                     hrdata,
    input  wire logic [irq_edge_pkg::PIN_N-1:0]  port_a_pin,
    input  wire logic                            low_voltage_detector,
    input  wire logic                            comparator_out,
    input  wire logic                            enable_interrupts_instr,
    input  wire logic                            disable_interrupts_instr,
    input  wire logic                            interrupt_return_instr,
    input  wire logic                            irq_ack,
    input  wire logic [REQ_N-1:0]                pending_req,
    input  wire logic [REQ_N-1:0]                enable_high,
    input  wire logic [REQ_N-1:0]                enable_low,
    output logic      [irq_edge_pkg::PIN_N-1:0]  pin_edge_q,
    output logic                                 global_interrupt_enable_q,
    output logic                                 core_irq_q,
    output logic      [1:0]                      core_irq_level_q
);
    import irq_edge_pkg::*;

    logic [PIN_N-1:0]  edge_polarity_select_q;
    logic [PIN_N-1:0]  edge_polarity_select_d;
    logic [7:0]        shared_source_select_q;
    logic [7:0]        shared_source_select_d;
    logic              gie_d;
    logic [PIN_N+1:0]  sync_lvl;
    logic [PIN_N-1:0]  sel_lvl;
    logic [PIN_N-1:0]  prev_lvl_q;
    logic              wr_pend_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic              addr_phase;
    logic              rd_ctl_q;
    logic              wr_eps;
    logic              wr_sss;
    logic              wr_mic;
    logic [1:0]        best_level;
    logic [7:0]        rd_mux;

    irq_sync_bank #(
        .W (PIN_N + 2)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({comparator_out, low_voltage_detector, port_a_pin}),
        .sync_out (sync_lvl)
    );

    // Shared lines are muxed before edge compare, so a source switch can look like an edge
    always_comb begin
        sel_lvl = sync_lvl[PIN_N-1:0];
        sel_lvl[LVD_SEL_BIT] = shared_source_select_q[LVD_SEL_BIT] ? sync_lvl[PIN_N]
                                                                    : sync_lvl[LVD_SEL_BIT];
        sel_lvl[CMP_SEL_BIT] = shared_source_select_q[CMP_SEL_BIT] ? sync_lvl[PIN_N+1]
                                                                    : sync_lvl[CMP_SEL_BIT];
    end

    genvar g;
    generate
        for (g = 0; g < PIN_N; g++) begin : g_edge
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    prev_lvl_q[g] <= 1'b0;
                    pin_edge_q[g] <= 1'b0;
                end else begin
                    prev_lvl_q[g] <= sel_lvl[g];
                    // Polarity 1 picks a rising edge, 0 a falling edge
                    pin_edge_q[g] <= edge_polarity_select_q[g] ? (sel_lvl[g] & ~prev_lvl_q[g])
                                                               : (~sel_lvl[g] & prev_lvl_q[g]);
                end
            end
        end
    endgenerate

    // AHB-Lite slave: zero wait states, always OKAY
    assign addr_phase = hsel && hready && htrans[1];
    assign wr_eps     = wr_pend_q && (wr_addr_q == EPS_ADDR);
    assign wr_sss     = wr_pend_q && (wr_addr_q == SSS_ADDR);
    assign wr_mic     = wr_pend_q && (wr_addr_q == MIC_ADDR);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= addr_phase && hwrite;
            wr_addr_q <= haddr;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb begin
        edge_polarity_select_d = wr_eps ? hwdata[PIN_N-1:0] : edge_polarity_select_q;
        // Reserved low bits are stored as written; software keeps them zero
        shared_source_select_d = wr_sss ? hwdata[7:0] : shared_source_select_q;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            edge_polarity_select_q <= EPS_RESET;
            shared_source_select_q <= SSS_RESET;
        end else begin
            edge_polarity_select_q <= edge_polarity_select_d;
            shared_source_select_q <= shared_source_select_d;
        end
    end

    // Clears win: an acknowledge must never leave the enable set
    always_comb begin
        gie_d = global_interrupt_enable_q;
        if (enable_interrupts_instr || interrupt_return_instr) begin
            gie_d = 1'b1;
        end
        if (wr_mic) begin
            gie_d = hwdata[GIE_BIT];
        end
        if (disable_interrupts_instr || irq_ack) begin
            gie_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            global_interrupt_enable_q <= GIE_RESET;
        end else begin
            global_interrupt_enable_q <= gie_d;
        end
    end

    // Read data from next values so a read right after a write sees the new contents
    always_comb begin
        rd_mux = 8'h00;
        unique case (haddr)
            EPS_ADDR: rd_mux = edge_polarity_select_d;
            SSS_ADDR: rd_mux = shared_source_select_d;
            MIC_ADDR: rd_mux = {gie_d, 7'h00};
            default:  rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hrdata   <= 32'h0000_0000;
            rd_ctl_q <= 1'b0;
        end else begin
            rd_ctl_q <= addr_phase && !hwrite && (haddr == MIC_ADDR);
            if (addr_phase && !hwrite) begin
                hrdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Highest priority among pending and enabled requests
    always_comb begin
        best_level = LEVEL_OFF;
        for (int i = 0; i < REQ_N; i++) begin
            if (pending_req[i] && ({enable_high[i], enable_low[i]} > best_level)) begin
                best_level = {enable_high[i], enable_low[i]};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            core_irq_q       <= 1'b0;
            core_irq_level_q <= LEVEL_OFF;
        end else begin
            core_irq_q       <= gie_d && (best_level != LEVEL_OFF);
            core_irq_level_q <= gie_d ? best_level : LEVEL_OFF;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    rise_edge_a: assert property (
        (edge_polarity_select_q[0] && sel_lvl[0] && !prev_lvl_q[0]) |=> pin_edge_q[0])
        else $error("rising edge on pin 0 not flagged");
    fall_edge_a: assert property (
        pin_edge_q[1] |-> ($past(prev_lvl_q[1]) != $past(sel_lvl[1]))
            && ($past(sel_lvl[1]) == $past(edge_polarity_select_q[1])))
        else $error("pin 1 edge flagged with wrong polarity");
    // Pin 7 must be masked while the detector is selected and holds still
    lvd_mux_a: assert property (
        (shared_source_select_q[LVD_SEL_BIT] && $past(shared_source_select_q[LVD_SEL_BIT])
            && $stable(sync_lvl[PIN_N])) |=> !pin_edge_q[LVD_SEL_BIT])
        else $error("shared line 7 edge from deselected pin");
    cmp_mux_a: assert property (
        (shared_source_select_q[CMP_SEL_BIT] && $past(shared_source_select_q[CMP_SEL_BIT])
            && $stable(sync_lvl[PIN_N+1])) |=> !pin_edge_q[CMP_SEL_BIT])
        else $error("shared line 6 edge from deselected pin");
    gie_set_a: assert property (
        ((enable_interrupts_instr || interrupt_return_instr) && !disable_interrupts_instr
            && !irq_ack && !wr_mic) |=> global_interrupt_enable_q)
        else $error("enable not set by instruction");
    gie_clear_a: assert property (
        (irq_ack || disable_interrupts_instr) |=> !global_interrupt_enable_q && !core_irq_q)
        else $error("enable not cleared by ack or disable");
    gate_block_a: assert property (
        (!gie_d && !enable_interrupts_instr) |=> !core_irq_q && core_irq_level_q == LEVEL_OFF)
        else $error("request passed while disabled");
    ctl_reserved_a: assert property (
        rd_ctl_q |-> hrdata[6:0] == 7'h00 && hrdata[7] == $past(gie_d))
        else $error("control register read wrong");
endmodule

// ===== hdl/irq_edge_pkg.sv
// Package with register map, reset values and field positions of the edge/source/enable block
package irq_edge_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          PIN_N           = 8;
    // Printed offsets are word indices; byte address is four times the index
    localparam logic [11:0] EPS_INDEX       = 12'hfcd;
    localparam logic [11:0] SSS_INDEX       = 12'hfce;
    localparam logic [11:0] MIC_INDEX       = 12'hfcf;
    localparam logic [15:0] EPS_ADDR        = {2'b00, EPS_INDEX, 2'b00};
    localparam logic [15:0] SSS_ADDR        = {2'b00, SSS_INDEX, 2'b00};
    localparam logic [15:0] MIC_ADDR        = {2'b00, MIC_INDEX, 2'b00};
    localparam logic [7:0]  EPS_RESET       = 8'h00;
    localparam logic [7:0]  SSS_RESET       = 8'h00;
    localparam logic        GIE_RESET       = 1'b0;
    localparam int          GIE_BIT         = 7;
    localparam int          LVD_SEL_BIT     = 7;
    localparam int          CMP_SEL_BIT     = 6;
    localparam int          SYNC_STAGES     = 2;
    localparam logic [1:0]  LEVEL_OFF       = 2'b00;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;
endpackage

// ===== hdl/irq_sync_bank.sv
// Two-stage synchroniser bank for asynchronous interrupt sources
`timescale 1ns/100ps
module irq_sync_bank #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    import irq_edge_pkg::*;

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ===== bench/core_model.sv
// Processor core model: instruction pulses and interrupt acknowledge
`timescale 1ns/100ps
module core_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] op_req,
    input  wire logic       ack_on,
    input  wire logic [3:0] ack_dly,
    input  wire logic       core_irq_q,
    output logic            en_pulse,
    output logic            dis_pulse,
    output logic            ret_pulse,
    output logic            irq_ack
);
    logic [3:0] wait_q;
    // Pulses last as long as the bench holds the code, one cycle
    assign en_pulse  = op_req == 2'h1;
    assign dis_pulse = op_req == 2'h2;
    assign ret_pulse = op_req == 2'h3;
    // Ack after a set delay; 0 gives a prompt core, larger a slow one
    always_ff @(posedge core_clk) begin
        if (!rst_n || !core_irq_q || !ack_on || irq_ack) begin
            wait_q  <= 4'h0;
            irq_ack <= 1'b0;
        end else if (wait_q == ack_dly) begin
            irq_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for edge, source and master enable logic
`timescale 1ns/100ps
module testbench;
    import irq_edge_pkg::*;
    logic        core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
    logic [15:0] haddr = 0;
    logic [1:0]  htrans = 0, op_req = 0, lvl;
    logic [31:0] hwdata = 0, hrdata, r, n;
    logic [7:0]  pins = 0, eps, edge_q;
    logic        lowv = 0, comp = 0, ack_on = 0, gie, irq, hrdy, hresp, en, dis, ret, ack;
    logic [3:0]  dly = 0;
    logic [23:0] pend = 0, eh = 0, el = 0;
    int          err_count = 0, cmp_count = 0, cyc = 0, i, k;
    irq_edge_source_master_ctl dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .port_a_pin(pins),
        .low_voltage_detector(lowv), .comparator_out(comp), .enable_interrupts_instr(en),
        .disable_interrupts_instr(dis), .interrupt_return_instr(ret), .irq_ack(ack),
        .pending_req(pend), .enable_high(eh), .enable_low(el), .pin_edge_q(edge_q),
        .global_interrupt_enable_q(gie), .core_irq_q(irq), .core_irq_level_q(lvl));
    core_model core (.core_clk(core_clk), .rst_n(rst_n), .op_req(op_req), .ack_on(ack_on),
        .ack_dly(dly), .core_irq_q(irq), .en_pulse(en), .dis_pulse(dis), .ret_pulse(ret),
        .irq_ack(ack));
    always #10 core_clk = !core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out;
        end
    end
    function automatic logic [1:0] exp_lvl(input logic [23:0] p, h, l);
        logic [1:0] m;
        m = 2'h0;
        for (int j = 0; j < 24; j++) if (p[j] && {h[j], l[j]} > m) m = {h[j], l[j]};
        return m;
    endfunction
    task chk(input string s, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    // Address phase held until hready, then data phase until hready again
    task ahb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1; htrans <= HTRANS_NONSEQ; haddr <= a; hwrite <= w;
        do @(posedge core_clk); while (hrdy !== 1'b1);
        hsel <= 0; htrans <= 2'b00; hwdata <= d;
        do @(posedge core_clk); while (hrdy !== 1'b1);
        r = hrdata;
        chk("hresp", 0, hresp);
    endtask
    // Pulses on one edge bit over eight cycles, sampled off the edge
    task cnt(input int b);
        n = 0;
        repeat (8) begin
            @(negedge core_clk);
            n = n + edge_q[b];
        end
    endtask
    task op(input logic [1:0] c, input logic e);
        @(posedge core_clk); op_req <= c;
        @(posedge core_clk); op_req <= 2'h0;
        @(negedge core_clk); chk("gie", e, gie);
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        n = $urandom(32'hab03);
        repeat (8) @(posedge core_clk);
        rst_n <= 1;
        ahb(0, EPS_ADDR, 0); chk("eps", EPS_RESET, r);
        ahb(0, SSS_ADDR, 0); chk("sss", SSS_RESET, r);
        ahb(0, MIC_ADDR, 0); chk("mic", {24'h00_0000, GIE_RESET, 7'h00}, r);
        ahb(1, 16'h0000, 32'hff); ahb(0, 16'h0000, 0); chk("unmapped", 0, r);
        ahb(1, MIC_ADDR, 32'hff); ahb(0, MIC_ADDR, 0); chk("mic", 32'h80, r);
        chk("gie", 1, gie);
        ahb(1, MIC_ADDR, 0); ahb(0, MIC_ADDR, 0); chk("mic", 0, r);
        eps = $urandom;
        ahb(1, SSS_ADDR, {eps[7:6], 6'h0});
        ahb(0, SSS_ADDR, 0); chk("sss", {eps[7:6], 6'h0}, r);
        ahb(1, SSS_ADDR, 0);
        eps = $urandom;
        ahb(1, EPS_ADDR, eps); ahb(0, EPS_ADDR, 0); chk("eps", eps, r);
        for (i = 0; i < 8; i++) for (k = 0; k < 2; k++) begin
            @(posedge core_clk); pins[i] <= !k;
            cnt(i); chk("edge", (!k) == eps[i], n);
        end
        // Requests stay disabled while sources are switched
        ahb(1, SSS_ADDR, 32'hc0);
        for (i = 6; i < 8; i++) begin
            @(posedge core_clk); if (i == 7) lowv <= 1; else comp <= 1;
            cnt(i); chk("shared", eps[i], n);
            @(posedge core_clk); pins[i] <= 1;
            cnt(i); chk("masked", 0, n);
            @(posedge core_clk); pins[i] <= 0;
        end
        ahb(1, SSS_ADDR, 32'h40); cnt(7); chk("switch", !eps[7], n);
        op(2'h1, 1);
        op(2'h2, 0);
        op(2'h3, 1);
        for (i = 0; i < 8; i++) begin
            @(posedge core_clk);
            pend <= (i == 0) ? 24'h0 : 24'(1 << ($urandom % 24));
            eh <= 24'($urandom); el <= 24'($urandom);
            @(posedge core_clk); @(negedge core_clk);
            chk("irq", exp_lvl(pend, eh, el) != 0, irq);
            chk("level", exp_lvl(pend, eh, el), lvl);
        end
        @(posedge core_clk); pend <= 24'h1; eh <= 24'h1;
        op(2'h2, 0); chk("irq", 0, irq); chk("level", 0, lvl);
        for (k = 0; k < 2; k++) begin
            @(posedge core_clk); ack_on <= 1; dly <= 4'(k * 5);
            op(2'h1, 1);
            repeat (10) @(negedge core_clk);
            chk("gie", 0, gie); chk("irq", 0, irq);
        end
        // Mid-run reset with the enable set and a request pending
        op(2'h1, 1);
        @(posedge core_clk); rst_n <= 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1;
        @(negedge core_clk); chk("gie", GIE_RESET, gie); chk("irq", 0, irq);
        ahb(0, SSS_ADDR, 0); chk("sss", SSS_RESET, r);
        close_out;
    end
endmodule
